// [verilog/crdc_pkg.sv]
package crdc_pkg;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [3:0] crdc_off_collision = 4'h0;
    localparam logic [3:0] crdc_off_dma_enable = 4'h1;
    localparam logic [3:0] crdc_off_burst = 4'h2;
    localparam logic [3:0] crdc_off_irq_status = 4'h3;
    localparam logic [3:0] crdc_off_irq_clear = 4'h4;
    localparam logic [3:0] crdc_off_irq_enable = 4'h5;
    localparam logic [3:0] crdc_off_state = 4'h6;

    // ************************************************************
    // field positions and codes
    // ************************************************************
    localparam int crdc_bit_skip = 0;
    localparam int crdc_bit_restart = 1;
    localparam int crdc_bit_nohalt = 2;
    localparam int crdc_bit_tx_dma = 0;
    localparam int crdc_bit_rx_dma = 1;
    localparam logic [7:0] crdc_code_repeat = 8'h02;
    localparam logic [7:0] crdc_code_skip = 8'h03;
    localparam logic [7:0] crdc_code_auto_repeat = 8'h06;
    localparam logic [7:0] crdc_code_auto_skip = 8'h07;

    // ************************************************************
    // reset values and counts
    // ************************************************************
    localparam logic [2:0] crdc_collision_reset = 3'h0;
    localparam logic [1:0] crdc_dma_reset = 2'h0;
    localparam logic [1:0] crdc_burst_reset = 2'h0;
    localparam logic [4:0] crdc_collision_limit = 5'h10;
    localparam logic [3:0] crdc_burst_len_0 = 4'h1;
    localparam logic [3:0] crdc_burst_len_1 = 4'h2;
    localparam logic [3:0] crdc_burst_len_2 = 4'h4;
    localparam logic [3:0] crdc_burst_len_3 = 4'hc;

    // interrupt status bits: halted, transmit done, transfer end
    localparam int crdc_irq_halt = 0;
    localparam int crdc_irq_done = 1;
    localparam int crdc_irq_eop = 2;

    typedef enum {crdc_idle, crdc_sending, crdc_halted} crdc_state_t;

    // events from the transmitter
    typedef struct packed {
        logic start;       // beginning an attempt of a packet
        logic collision;   // attempt ended in a collision
        logic success;     // packet sent
        logic more;        // another packet waits behind this one
    } crdc_tx_event_t;

    // commands to the transmitter
    typedef struct packed {
        logic retry;       // attempt the same packet again
        logic discard;     // drop packet, go to next
        logic go_idle;     // no packet left
    } crdc_tx_cmd_t;
endpackage

// [verilog/crdc_collision_dma_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module crdc_collision_dma_ctrl
    import crdc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // transmitter side
    input wire crdc_tx_event_t tx_event,
    output crdc_tx_cmd_t tx_cmd,
    output logic tx_halted,
    output logic tx_done,
    // dma side
    input wire logic transfer_end,
    input wire logic system_word_mode,
    output logic rx_dma_enable,
    output logic tx_dma_enable,
    output logic dma_terminate,
    output logic [3:0] burst_length,
    output logic burst_unit_word,
    output logic transfer_end_flag,
    // interrupt
    output logic irq
);
    // ************************************************************
    // registers
    // ************************************************************
    // software-visible state
    logic [2:0] collision_action_control;
    logic [1:0] dma_enable_control;
    logic [1:0] burst_transceiver_mode;
    logic [2:0] irq_status;
    logic [2:0] irq_enable;
    // transmitter tracking
    logic [4:0] collision_count;
    crdc_state_t state;
    // decoded strobes and events
    logic wr_coll;
    logic wr_dma;
    logic halt_hit;
    logic resume;
    logic resume_skip;
    // interrupt set and clear vectors
    logic [2:0] irq_set;
    logic [2:0] irq_clr;

    assign wr_coll = reg_write && (reg_addr == crdc_off_collision);
    assign wr_dma = reg_write && (reg_addr == crdc_off_dma_enable);
    // sixteenth consecutive collision on this packet
    assign halt_hit = tx_event.collision
        && (collision_count == (crdc_collision_limit - 5'h01));
    // repeat or skip code (restart set, nohalt clear) written while halted
    assign resume = wr_coll && (state == crdc_halted)
        && reg_wdata[crdc_bit_restart] && !reg_wdata[crdc_bit_nohalt];
    assign resume_skip = resume && reg_wdata[crdc_bit_skip];

    // ************************************************************
    // collision register: mode bits and restart command
    // ************************************************************
    // mode bits stored; restart bit cleared by hardware at packet start unless the nohalt bit is set
    // a software write wins over the hardware clear in the same cycle
    always_ff @(posedge clock)
    begin
        if (!resetn)
            collision_action_control <= crdc_collision_reset;
        else if (wr_coll)
            collision_action_control <= reg_wdata[2:0];
        else if (tx_event.start && !collision_action_control[crdc_bit_nohalt])
            collision_action_control[crdc_bit_restart] <= 1'b0;
    end

    // ************************************************************
    // collision counter and halt state
    // ************************************************************
    // counts consecutive collisions of the current packet;
    // cleared at the sixteenth too, so each retry round starts afresh
    always_ff @(posedge clock)
    begin
        if (!resetn)
            collision_count <= 5'h00;
        else if (resume || tx_event.success || halt_hit)
            collision_count <= 5'h00;
        else if (tx_event.collision)
            collision_count <= collision_count + 5'h01;
    end

    // transmitter run state
    // halt persists until software writes a code with restart set and nohalt clear (repeat or skip)
    always_ff @(posedge clock)
    begin
        if (!resetn)
            state <= crdc_idle;
        else
            case (state)
                crdc_idle:
                    if (tx_event.start)
                        state <= crdc_sending;
                crdc_sending:
                    if (halt_hit && !collision_action_control[crdc_bit_nohalt])
                        state <= crdc_halted;
                    else if (halt_hit && collision_action_control[crdc_bit_skip]
                        && !tx_event.more)
                        state <= crdc_idle;
                    else if (tx_event.success && !tx_event.more)
                        state <= crdc_idle;
                crdc_halted:
                    if (resume_skip && !tx_event.more)
                        state <= crdc_idle;
                    else if (resume)
                        state <= crdc_sending;
                default:
                    state <= crdc_idle;
            endcase
    end

    // transmitter commands, one-cycle pulses from flip-flops
    // automatic modes act at the sixteenth collision without halting
    always_ff @(posedge clock)
    begin
        if (!resetn)
            tx_cmd <= '0;
        else
        begin
            tx_cmd.retry <= (resume && !resume_skip)
                || (state == crdc_sending && halt_hit
                    && collision_action_control[crdc_bit_nohalt]
                    && !collision_action_control[crdc_bit_skip]);
            tx_cmd.discard <= resume_skip
                || (state == crdc_sending && halt_hit
                    && collision_action_control[crdc_bit_nohalt]
                    && collision_action_control[crdc_bit_skip]);
            tx_cmd.go_idle <= (resume_skip && !tx_event.more)
                || (state == crdc_sending && !tx_event.more
                    && (tx_event.success || (halt_hit
                        && collision_action_control[crdc_bit_nohalt]
                        && collision_action_control[crdc_bit_skip])));
        end
    end

    // ************************************************************
    // dma enable and burst
    // ************************************************************
    // write-only enables; reserved bits dropped
    // no read path, so software must keep its own copy
    always_ff @(posedge clock)
    begin
        if (!resetn)
            dma_enable_control <= crdc_dma_reset;
        else if (wr_dma)
            dma_enable_control <= reg_wdata[1:0];
    end

    // terminate pulse when both enables written zero
    always_ff @(posedge clock)
    begin
        if (!resetn)
            dma_terminate <= 1'b0;
        else
            dma_terminate <= wr_dma && (reg_wdata[1:0] == 2'h0);
    end

    // burst length code
    always_ff @(posedge clock)
    begin
        if (!resetn)
            burst_transceiver_mode <= crdc_burst_reset;
        else if (reg_write && reg_addr == crdc_off_burst)
            burst_transceiver_mode <= reg_wdata[1:0];
    end

    // decoded burst length
    // code 3 gives the longest burst
    always_comb
    begin
        case (burst_transceiver_mode)
            2'h0: burst_length = crdc_burst_len_0;
            2'h1: burst_length = crdc_burst_len_1;
            2'h2: burst_length = crdc_burst_len_2;
            default: burst_length = crdc_burst_len_3;
        endcase
    end

    assign burst_unit_word = system_word_mode;
    assign rx_dma_enable = dma_enable_control[crdc_bit_rx_dma];
    assign tx_dma_enable = dma_enable_control[crdc_bit_tx_dma];
    assign tx_halted = (state == crdc_halted);
    assign tx_done = irq_status[crdc_irq_done];
    assign transfer_end_flag = irq_status[crdc_irq_eop];

    // ************************************************************
    // interrupts
    // ************************************************************
    // halt, done and transfer end events
    assign irq_set[crdc_irq_halt] = (state == crdc_sending) && halt_hit
        && !collision_action_control[crdc_bit_nohalt];
    assign irq_set[crdc_irq_done] = tx_cmd.go_idle;
    assign irq_set[crdc_irq_eop] = transfer_end;
    assign irq_clr = (reg_write && reg_addr == crdc_off_irq_clear) ? reg_wdata[2:0] : 3'h0;

    // sticky status, set wins over clear
    // a transfer end in the clearing cycle is kept, never lost
    always_ff @(posedge clock)
    begin
        if (!resetn)
            irq_status <= 3'h0;
        else
        begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
            if (dma_terminate && !transfer_end)
                irq_status[crdc_irq_eop] <= 1'b0;
        end
    end

    // interrupt enables
    always_ff @(posedge clock)
    begin
        if (!resetn)
            irq_enable <= 3'h0;
        else if (reg_write && reg_addr == crdc_off_irq_enable)
            irq_enable <= reg_wdata[2:0];
    end

    assign irq = |(irq_status & irq_enable);

    // ************************************************************
    // read data
    // ************************************************************
    // one cycle after read strobe; write-only and unmapped read zero
    // zero outside the answer cycle keeps the bus quiet
    always_ff @(posedge clock)
    begin
        if (!resetn)
            reg_rdata <= 8'h00;
        else if (!reg_read)
            reg_rdata <= 8'h00;
        else if (reg_addr == crdc_off_collision)
            reg_rdata <= {5'h00, collision_action_control};
        else if (reg_addr == crdc_off_irq_status)
            reg_rdata <= {5'h00, irq_status};
        else if (reg_addr == crdc_off_irq_enable)
            reg_rdata <= {5'h00, irq_enable};
        else if (reg_addr == crdc_off_state)
            reg_rdata <= {1'b0, tx_halted, collision_count, 1'b0};
        else
            reg_rdata <= 8'h00;
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_halt_on_sixteen: assert property (@(posedge clock) disable iff (!resetn)
        (state == crdc_sending && halt_hit && !collision_action_control[crdc_bit_nohalt])
        |=> tx_halted) else $error("no halt after sixteen collisions");
    a_resume_repeat: assert property (@(posedge clock) disable iff (!resetn)
        (resume && !resume_skip) |=> tx_cmd.retry && !tx_halted && collision_count == 5'h00)
        else $error("repeat resume failed");
    a_resume_skip: assert property (@(posedge clock) disable iff (!resetn)
        resume_skip |=> tx_cmd.discard) else $error("skip resume failed");
    a_skip_done: assert property (@(posedge clock) disable iff (!resetn)
        (resume_skip && !tx_event.more) |=> ##1 tx_done) else $error("done not set");
    a_auto_no_halt: assert property (@(posedge clock) disable iff (!resetn)
        (collision_action_control[crdc_bit_nohalt] && !wr_coll && state != crdc_halted)
        |=> !tx_halted) else $error("halted in auto mode");
    a_restart_clear: assert property (@(posedge clock) disable iff (!resetn)
        (tx_event.start && !wr_coll && !collision_action_control[crdc_bit_nohalt])
        |=> !collision_action_control[crdc_bit_restart]) else $error("restart kept");
    a_dma_bits: assert property (@(posedge clock) disable iff (!resetn)
        wr_dma |=> rx_dma_enable == $past(reg_wdata[1]) && tx_dma_enable == $past(reg_wdata[0]))
        else $error("dma enable mismatch");
    a_eop_clear: assert property (@(posedge clock) disable iff (!resetn)
        (wr_dma && reg_wdata[1:0] == 2'h0 && !transfer_end) ##1 !transfer_end
        |=> !transfer_end_flag) else $error("end flag not cleared");
    a_burst_max: assert property (@(posedge clock) disable iff (!resetn)
        burst_transceiver_mode == 2'h3 |-> burst_length == 4'hc)
        else $error("burst length wrong");
    a_count_bound: assert property (@(posedge clock) disable iff (!resetn)
        collision_count < crdc_collision_limit) else $error("count overflow");

    // automatic continuation
    a_auto_repeat: assert property (@(posedge clock) disable iff (!resetn)
        (state == crdc_sending && halt_hit && collision_action_control[crdc_bit_nohalt]
        && !collision_action_control[crdc_bit_skip]) |=> tx_cmd.retry && !tx_halted)
        else $error("no automatic retry");
    a_auto_skip: assert property (@(posedge clock) disable iff (!resetn)
        (state == crdc_sending && halt_hit && collision_action_control[crdc_bit_nohalt]
        && collision_action_control[crdc_bit_skip]) |=> tx_cmd.discard && !tx_halted)
        else $error("no automatic skip");
    a_auto_restart: assert property (@(posedge clock) disable iff (!resetn)
        (tx_event.start && !wr_coll && collision_action_control[crdc_bit_nohalt])
        |=> collision_action_control == $past(collision_action_control))
        else $error("mode bits changed");

    // halt, resume and counting
    a_halt_holds: assert property (@(posedge clock) disable iff (!resetn)
        (tx_halted && !resume) |=> tx_halted) else $error("halt left without command");
    a_skip_count: assert property (@(posedge clock) disable iff (!resetn)
        resume_skip |=> collision_count == 5'h00 && !tx_halted) else $error("skip count kept");
    a_success_count: assert property (@(posedge clock) disable iff (!resetn)
        tx_event.success |=> collision_count == 5'h00) else $error("count kept");
    a_done_set: assert property (@(posedge clock) disable iff (!resetn)
        tx_cmd.go_idle |=> tx_done) else $error("done missing after idle");
    a_mode_write: assert property (@(posedge clock) disable iff (!resetn)
        wr_coll |=> collision_action_control == $past(reg_wdata[2:0]))
        else $error("collision register write lost");

    // dma, burst and read port
    a_term_pulse: assert property (@(posedge clock) disable iff (!resetn)
        (wr_dma && reg_wdata[1:0] == 2'h0)
        |=> dma_terminate && !rx_dma_enable && !tx_dma_enable) else $error("dma not ended");
    a_burst_min: assert property (@(posedge clock) disable iff (!resetn)
        burst_transceiver_mode == 2'h0 |-> burst_length == 4'h1)
        else $error("burst short wrong");
    a_wo_read: assert property (@(posedge clock) disable iff (!resetn)
        (reg_read && reg_addr == crdc_off_dma_enable) |=> reg_rdata == 8'h00)
        else $error("dma enable readable");
endmodule
`default_nettype wire

// [dv/crdc_tx_model.sv]
`timescale 1ns/1ps
`default_nettype none
module crdc_tx_model
    import crdc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // bench control
    input wire logic kick,
    input wire logic collide,
    input wire logic load,
    input wire logic [3:0] queued_init,
    // transmitter link
    input wire crdc_tx_cmd_t tx_cmd,
    input wire logic tx_halted,
    output crdc_tx_event_t tx_event
);
    logic busy;
    logic start;
    logic col;
    logic ok;
    logic [1:0] gap;
    logic [3:0] queued;
    // new attempt on kick, retry, or skip to a waiting packet
    wire logic go = kick | tx_cmd.retry | (tx_cmd.discard & ~tx_cmd.go_idle);
    wire logic fire = busy & (gap == 2'h0) & ~go;
    assign tx_event = {start, col, ok, queued > 4'h1};
    // attempt sequencer: one outcome every third cycle
    always_ff @(posedge clock)
    begin
        start <= resetn & go;
        col <= resetn & fire & collide;
        ok <= resetn & fire & ~collide;
        gap <= (!resetn | go | fire) ? 2'h2 : gap - {1'b0, gap != 2'h0};
        busy <= resetn & (go | (busy & ~tx_halted & ~tx_cmd.go_idle & ~(fire & ~collide)));
        if (!resetn)
            queued <= 4'h0;
        else if (load)
            queued <= queued_init;
        else if (tx_cmd.discard | (fire & ~collide))
            queued <= queued - 4'h1;
    end
endmodule
`default_nettype wire

// [dv/crdc_collision_dma_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module crdc_collision_dma_ctrl_tb
    import crdc_pkg::*;
;
    logic clock, resetn, reg_write, reg_read, transfer_end, system_word_mode;
    logic kick, collide, load, tx_halted, tx_done, rx_dma_enable, tx_dma_enable;
    logic dma_terminate, burst_unit_word, transfer_end_flag, irq;
    logic [3:0] reg_addr, burst_length, queued_init;
    logic [7:0] reg_wdata, reg_rdata;
    crdc_tx_event_t tx_event;
    crdc_tx_cmd_t tx_cmd;
    int bad_count = 0, compares = 0, cycles = 0, n_retry, n_disc, n_idle, n_col;
    // ************************************************************
    // design, transmitter model, clock
    // ************************************************************
    crdc_collision_dma_ctrl crdc_collision_dma_ctrl_i (.clock(clock), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .tx_event(tx_event), .tx_cmd(tx_cmd),
        .tx_halted(tx_halted), .tx_done(tx_done), .transfer_end(transfer_end),
        .system_word_mode(system_word_mode), .rx_dma_enable(rx_dma_enable),
        .tx_dma_enable(tx_dma_enable), .dma_terminate(dma_terminate),
        .burst_length(burst_length), .burst_unit_word(burst_unit_word),
        .transfer_end_flag(transfer_end_flag), .irq(irq));
    crdc_tx_model crdc_tx_model_i (.clock(clock), .resetn(resetn), .kick(kick),
        .collide(collide), .load(load), .queued_init(queued_init), .tx_cmd(tx_cmd),
        .tx_halted(tx_halted), .tx_event(tx_event));
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // event counters and hang limit
    always @(posedge clock)
    begin
        cycles++;
        n_retry += tx_cmd.retry;
        n_disc += tx_cmd.discard;
        n_idle += tx_cmd.go_idle;
        n_col += tx_event.collision;
        if (cycles == 5000)
        begin
            bad_count++;
            print_verdict;
        end
    end
    // ************************************************************
    // shared tasks
    // ************************************************************
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        chk(reg_rdata, e);
    endtask
    task send(input logic [3:0] n, input logic k);
        @(posedge clock);
        queued_init <= n;
        load <= 1'b1;
        kick <= k;
        @(posedge clock);
        load <= 1'b0;
        kick <= 1'b0;
    endtask
    task clr;
        @(negedge clock);
        n_retry = 0;
        n_disc = 0;
        n_idle = 0;
        n_col = 0;
    endtask
    task wait_halt;
        @(negedge clock);
        for (int n = 0; n < 200 && tx_halted !== 1'b1; n++)
            @(negedge clock);
    endtask
    task print_verdict;
        if (bad_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task t_halt_repeat;
        rd_chk(crdc_off_collision, 8'h00);
        rd_chk(4'hf, 8'h00);
        wr(crdc_off_irq_enable, 8'h01);
        wr(crdc_off_collision, crdc_code_repeat);
        clr;
        send(4'h1, 1'b1);
        wait_halt;
        repeat (2) @(negedge clock);
        chk(8'(n_col), 8'h10);
        chk({6'h0, tx_halted, irq}, 8'h03);
        rd_chk(crdc_off_state, 8'h40);
        wr(crdc_off_irq_enable, 8'h00);
        repeat (2) @(negedge clock);
        chk(8'(irq), 8'h00);
        clr;
        wr(crdc_off_collision, crdc_code_repeat);
        repeat (3) @(negedge clock);
        chk({7'h0, tx_halted}, 8'h00);
        chk(8'(n_retry), 8'h01);
        rd_chk(crdc_off_collision, 8'h00);
        wait_halt;
        chk(8'(n_col), 8'h10);
    endtask
    task t_skip;
        send(4'h2, 1'b0);
        clr;
        wr(crdc_off_collision, crdc_code_skip);
        wait_halt;
        chk({4'h0, 2'(n_disc), 1'(n_idle), tx_halted}, 8'h05);
        chk(8'(n_col), 8'h10);
        clr;
        wr(crdc_off_collision, crdc_code_skip);
        repeat (3) @(negedge clock);
        chk({6'h0, 1'(n_idle), tx_done}, 8'h03);
        rd_chk(crdc_off_irq_status, 8'h03);
        wr(crdc_off_irq_clear, 8'h07);
        rd_chk(crdc_off_irq_status, 8'h00);
    endtask
    task t_auto;
        wr(crdc_off_collision, crdc_code_auto_repeat);
        clr;
        send(4'h1, 1'b1);
        repeat (120) @(negedge clock);
        chk({6'h0, tx_halted, n_retry >= 2}, 8'h01);
        chk({7'h0, n_col > 16}, 8'h01);
        rd_chk(crdc_off_collision, crdc_code_auto_repeat);
        @(posedge clock);
        collide <= 1'b0;
        repeat (8) @(negedge clock);
        chk(8'(n_idle), 8'h01);
        wr(crdc_off_collision, crdc_code_auto_skip);
        collide <= 1'b1;
        clr;
        send(4'h2, 1'b1);
        for (int n = 0; n < 300 && n_idle == 0; n++)
            @(negedge clock);
        chk({3'h0, 2'(n_disc), 2'(n_idle), tx_halted}, 8'h12);
    endtask
    task t_dma;
        logic [3:0] lens [4] = '{4'h1, 4'h2, 4'h4, 4'hc};
        wr(crdc_off_dma_enable, 8'h02);
        @(negedge clock);
        chk({6'h0, rx_dma_enable, tx_dma_enable}, 8'h02);
        wr(crdc_off_dma_enable, 8'h01);
        @(negedge clock);
        chk({6'h0, rx_dma_enable, tx_dma_enable}, 8'h01);
        rd_chk(crdc_off_dma_enable, 8'h00);
        wr(crdc_off_irq_enable, 8'h04);
        transfer_end <= 1'b1;
        @(posedge clock);
        transfer_end <= 1'b0;
        repeat (2) @(negedge clock);
        chk({6'h0, transfer_end_flag, irq}, 8'h03);
        wr(crdc_off_dma_enable, 8'h00);
        @(negedge clock);
        chk({6'h0, dma_terminate, tx_dma_enable}, 8'h02);
        repeat (2) @(negedge clock);
        chk({6'h0, transfer_end_flag, irq}, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            wr(crdc_off_burst, 8'(i));
            system_word_mode <= i[0];
            @(negedge clock);
            chk({3'h0, burst_unit_word, burst_length}, {3'h0, i[0], lens[i]});
        end
    endtask
    // reset, then every scenario in turn
    initial
    begin
        resetn = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        transfer_end = 1'b0;
        system_word_mode = 1'b0;
        kick = 1'b0;
        collide = 1'b1;
        load = 1'b0;
        queued_init = 4'h0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        chk({4'h0, burst_length}, 8'h01);
        t_halt_repeat;
        t_skip;
        t_auto;
        t_dma;
        print_verdict;
    end
endmodule
`default_nettype wire
